/* File: design/rcc_config_bank.sv */
// configuration bank and output routing of a room temperature controller
// assumes a synchronous register port driven by the field-bus slave logic,
// valve demand from the control loop and synchronous contact inputs
//
// Contract
// - application 0: every valve and aux output follows bus-written values
// - outputs unused by the application stay under bus control
// - application 1: heating only on first switched or analogue output
// - application 2: change-over on first output, mode from change-over reg
// - application 3: cooling only on first switched or analogue output
// - application 5, default: heating on first pair, cooling on second
// - applications 7, 8, 9 drive the same demand on both output pairs
// - power-up operating mode reset to reduced; its register is only stored and read back
// - signed offset added to on-board sensor, ignored for bus temperature
// - aux function 0 none, 1 second window contact
// - aux contact status readable always, 1 open, 0 closed
// - aux function 2: open selects cooling, closed heating
// - aux function 3: open means condensation, cooling disabled, flagged
// - aux function 4: presence 1 while contact closed, 0 while open
// - PWM period from cycle time 20..600 s, also 3-point run time
// - sensor select 1 on-board, 2 bus temperature register
// - dynamic correction 0..5, reset to stage 2
// - output type 0 PWM on switched outputs, 1 level on analogue
// - type 2 heat PWM first, cool analogue second; type 3 the reverse
// - type 4 switched outputs open and close a 3-point valve
// - window polarity 0 closed contact means closed, 1 open means closed
`timescale 1ns/1ps
`default_nettype none
module rcc_config_bank #(
    parameter int TICK_CYCLES = rcc_pkg::RCC_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire rcc_pkg::rcc_req_type req,
    output logic [31:0] rdata,
    output logic rvalid,
    // field inputs
    input wire logic window_contact_in,
    input wire logic aux_contact_in,
    input wire logic signed [15:0] sensor_temp,
    input wire logic [6:0] heat_demand_in,
    input wire logic [6:0] cool_demand_in,
    // outputs
    output rcc_pkg::rcc_valve_type valve_out,
    output logic aux_out,
    output logic signed [15:0] room_temp,
    output logic [2:0] op_mode,
    output logic [2:0] dyn_corr,
    output logic cooling_mode,
    output logic dew_point,
    output logic presence,
    output logic window_closed
);
    import rcc_pkg::*;

    logic signed [15:0] offset_reg;
    logic [3:0] app_reg;
    logic [2:0] aux_reg;
    logic [9:0] cycle_reg;
    logic [1:0] sensor_reg;
    logic [2:0] pwrup_reg;
    logic [2:0] dyn_reg;
    logic [2:0] otype_reg;
    logic pol_reg;
    logic signed [15:0] bus_temp_reg;
    logic bus_cool_reg;
    logic [3:0] bus_out_reg;
    logic [6:0] bus_ana_a_reg;
    logic [6:0] bus_ana_b_reg;
    logic [2:0] mode_reg;
    logic [31:0] tick_cnt_reg;
    logic [9:0] sec_cnt_reg;
    logic [9:0] pos_reg;
    logic [9:0] target_reg;

    wire wr_app = req.wr && req.idx == RCC_IDX_APP_SELECT;
    wire wr_cycle = req.wr && req.idx == RCC_IDX_CYCLE_TIME;
    wire [9:0] w10 = req.wdata[9:0];
    wire [2:0] w3 = req.wdata[2:0];
    wire signed [15:0] w16 = req.wdata[15:0];
    wire hi_zero = req.wdata[31:10] == 22'h0;

    // selector code checks
    wire app_ok = req.wdata[31:4] == 28'h0 &&
        (req.wdata[3:0] <= 4'h3 || req.wdata[3:0] == 4'h5 ||
         (req.wdata[3:0] >= 4'h7 && req.wdata[3:0] <= 4'h9));
    wire aux_ok = hi_zero && w10 <= 10'h004;
    wire otype_ok = hi_zero && w10 <= 10'h004;
    wire sensor_ok = hi_zero && (w10 == 10'h001 || w10 == 10'h002);
    wire mode_ok = hi_zero &&
        (w10 <= 10'h002 || w10 == 10'h005);
    wire cycle_ok = hi_zero && w10 >= RCC_CYCLE_MIN && w10 <= RCC_CYCLE_MAX;
    wire dyn_ok = hi_zero && w10 <= {7'h0, RCC_DYN_MAX};
    wire offset_ok = w16 >= RCC_OFFSET_MIN && w16 <= RCC_OFFSET_MAX;

    // aux contact decode
    wire aux_open = aux_contact_in;
    wire aux_changeover = aux_reg == RCC_AUX_CHANGEOVER;
    wire cool_now = aux_changeover ? aux_open : bus_cool_reg;
    wire dew_now = aux_reg == RCC_AUX_DEWPOINT && aux_open;
    wire pres_now = aux_reg == RCC_AUX_PRESENCE && !aux_open;
    wire win1_closed = pol_reg ? window_contact_in : !window_contact_in;
    wire win2_closed = aux_reg == RCC_AUX_WINDOW ?
        (pol_reg ? aux_open : !aux_open) : 1'b1;
    wire win_now = win1_closed && win2_closed;

    // temperature source
    wire signed [15:0] temp_now = sensor_reg == RCC_SENSOR_BUS ? bus_temp_reg
        : 16'(sensor_temp + offset_reg);

    // demand per role
    wire [6:0] heat_d = heat_demand_in;
    wire [6:0] cool_d = dew_now ? 7'h0 : cool_demand_in;
    wire [6:0] co_d = cool_now ? cool_d : heat_d;
    wire [3:0] a = app_reg;
    wire use_a = a != RCC_APP_BUS;
    wire use_b = a == RCC_APP_FOUR_PIPE || a >= RCC_APP_HEAT_DUAL;
    wire [6:0] dem_a = (a == RCC_APP_HEAT || a == RCC_APP_HEAT_DUAL) ? heat_d :
        (a == RCC_APP_COOL || a == RCC_APP_COOL_DUAL) ? cool_d :
        (a == RCC_APP_FOUR_PIPE) ? heat_d : co_d;
    wire [6:0] dem_b = a == RCC_APP_FOUR_PIPE ? cool_d : dem_a;

    // one-second tick and pwm period
    wire tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
    wire [9:0] period_end = cycle_reg - 10'h001;
    wire [16:0] on_a = 17'(dem_a) * 17'(cycle_reg);
    wire [16:0] on_b = 17'(dem_b) * 17'(cycle_reg);
    wire [16:0] sec_x = 17'(sec_cnt_reg) * 17'(RCC_DEMAND_MAX);
    wire pwm_a = sec_x < on_a;
    wire pwm_b = sec_x < on_b;

    // 3-point: position tracks demand over full run time
    wire [16:0] tgt_x = 17'(dem_a) * 17'(cycle_reg);
    wire [9:0] tgt_now = 10'(tgt_x / 17'(RCC_DEMAND_MAX));
    wire tp_open = pos_reg < target_reg;
    wire tp_close = pos_reg > target_reg;

    // output routing
    wire three_pt = otype_reg == RCC_OUT_THREE_POINT;
    wire sw_a_on = otype_reg == RCC_OUT_PWM || otype_reg == RCC_OUT_HPWM_CANA;
    wire sw_b_on = otype_reg == RCC_OUT_PWM || otype_reg == RCC_OUT_HANA_CPWM;
    wire an_a_on = otype_reg == RCC_OUT_ANALOG ||
        otype_reg == RCC_OUT_HANA_CPWM;
    wire an_b_on = otype_reg == RCC_OUT_ANALOG ||
        otype_reg == RCC_OUT_HPWM_CANA;
    wire sw_a_next = three_pt ? (use_a ? tp_open : bus_out_reg[0]) :
        (use_a && sw_a_on) ? pwm_a : bus_out_reg[0];
    wire sw_b_next = three_pt ? (use_a ? tp_close : bus_out_reg[1]) :
        (use_b && sw_b_on) ? pwm_b : bus_out_reg[1];
    wire [6:0] an_a_next = (use_a && an_a_on) ? dem_a : bus_ana_a_reg;
    wire [6:0] an_b_next = (use_b && an_b_on) ? dem_b : bus_ana_b_reg;

    // read mux
    logic [31:0] rd_next;
    always_comb begin
        case (req.idx)
            RCC_IDX_TEMP_OFFSET: rd_next = 32'(offset_reg);
            RCC_IDX_APP_SELECT: rd_next = {28'h0, app_reg};
            RCC_IDX_AUX_FUNC: rd_next = {29'h0, aux_reg};
            RCC_IDX_CYCLE_TIME: rd_next = {22'h0, cycle_reg};
            RCC_IDX_SENSOR_SEL: rd_next = {30'h0, sensor_reg};
            RCC_IDX_BUS_TEMP: rd_next = 32'(bus_temp_reg);
            RCC_IDX_POWERUP_MODE: rd_next = {29'h0, pwrup_reg};
            RCC_IDX_DYN_CORR: rd_next = {29'h0, dyn_reg};
            RCC_IDX_CHANGEOVER: rd_next = {31'h0, cool_now};
            RCC_IDX_DEWPOINT: rd_next = {31'h0, dew_now};
            RCC_IDX_PRESENCE: rd_next = {31'h0, pres_now};
            RCC_IDX_EFF_TEMP: rd_next = 32'(temp_now);
            RCC_IDX_WINDOW_STAT: rd_next = {31'h0, window_contact_in};
            RCC_IDX_AUX_STAT: rd_next = {31'h0, aux_open};
            RCC_IDX_OUT_TYPE: rd_next = {29'h0, otype_reg};
            RCC_IDX_WIN_POLARITY: rd_next = {31'h0, pol_reg};
            RCC_IDX_BUS_OUTPUTS: rd_next = {28'h0, bus_out_reg};
            RCC_IDX_HEAT_DEMAND: rd_next = {25'h0, bus_ana_a_reg};
            RCC_IDX_COOL_DEMAND: rd_next = {25'h0, bus_ana_b_reg};
            RCC_IDX_OPMODE: rd_next = {29'h0, mode_reg};
            default: rd_next = 32'h0;
        endcase
    end

    // configuration registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            offset_reg <= 16'sh0;
            app_reg <= RCC_RST_APP;
            aux_reg <= RCC_RST_AUX;
            cycle_reg <= RCC_RST_CYCLE;
            sensor_reg <= RCC_RST_SENSOR;
            pwrup_reg <= RCC_RST_PWRUP;
            dyn_reg <= RCC_RST_DYN;
            otype_reg <= RCC_RST_OUT_TYPE;
            pol_reg <= 1'b0;
        end else if (req.wr) begin
            if (req.idx == RCC_IDX_TEMP_OFFSET && offset_ok)
                offset_reg <= w16;
            if (wr_app && app_ok)
                app_reg <= req.wdata[3:0];
            if (req.idx == RCC_IDX_AUX_FUNC && aux_ok)
                aux_reg <= w3;
            if (wr_cycle && cycle_ok)
                cycle_reg <= w10;
            if (req.idx == RCC_IDX_SENSOR_SEL && sensor_ok)
                sensor_reg <= w10[1:0];
            if (req.idx == RCC_IDX_POWERUP_MODE && mode_ok)
                pwrup_reg <= w3;
            if (req.idx == RCC_IDX_DYN_CORR && dyn_ok)
                dyn_reg <= w3;
            if (req.idx == RCC_IDX_OUT_TYPE && otype_ok)
                otype_reg <= w3;
            if (req.idx == RCC_IDX_WIN_POLARITY && hi_zero && w10 <= 10'h001)
                pol_reg <= req.wdata[0];
        end
    end

    // bus-driven values and operating mode
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_temp_reg <= 16'sh0;
            bus_cool_reg <= 1'b0;
            bus_out_reg <= 4'h0;
            bus_ana_a_reg <= 7'h0;
            bus_ana_b_reg <= 7'h0;
            mode_reg <= RCC_RST_PWRUP;
        end else if (req.wr) begin
            if (req.idx == RCC_IDX_BUS_TEMP)
                bus_temp_reg <= w16;
            if (req.idx == RCC_IDX_CHANGEOVER && !aux_changeover)
                bus_cool_reg <= req.wdata[0];
            if (req.idx == RCC_IDX_BUS_OUTPUTS)
                bus_out_reg <= req.wdata[3:0];
            if (req.idx == RCC_IDX_HEAT_DEMAND && w10 <= 10'h064)
                bus_ana_a_reg <= req.wdata[6:0];
            if (req.idx == RCC_IDX_COOL_DEMAND && w10 <= 10'h064)
                bus_ana_b_reg <= req.wdata[6:0];
            if (req.idx == RCC_IDX_OPMODE && mode_ok)
                mode_reg <= w3;
        end
    end

    // second tick, pwm period and 3-point position
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_reg <= 32'h0;
            sec_cnt_reg <= 10'h0;
            pos_reg <= 10'h0;
            target_reg <= 10'h0;
        end else begin
            tick_cnt_reg <= (tick || wr_cycle) ? 32'h0 : tick_cnt_reg + 32'h1;
            target_reg <= tgt_now;
            if (wr_cycle) begin
                sec_cnt_reg <= 10'h0;
            end else if (tick) begin
                sec_cnt_reg <= sec_cnt_reg >= period_end ? 10'h0 :
                    sec_cnt_reg + 10'h1;
                if (tp_open)
                    pos_reg <= pos_reg + 10'h1;
                else if (tp_close)
                    pos_reg <= pos_reg - 10'h1;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            valve_out <= '0;
            aux_out <= 1'b0;
            room_temp <= 16'sh0;
            op_mode <= RCC_RST_PWRUP;
            dyn_corr <= RCC_RST_DYN;
            cooling_mode <= 1'b0;
            dew_point <= 1'b0;
            presence <= 1'b0;
            window_closed <= 1'b0;
            rdata <= 32'h0;
            rvalid <= 1'b0;
        end else begin
            valve_out <= '{sw_a_next, sw_b_next, an_a_next, an_b_next};
            aux_out <= bus_out_reg[2];
            room_temp <= temp_now;
            op_mode <= mode_reg;
            dyn_corr <= dyn_reg;
            cooling_mode <= cool_now;
            dew_point <= dew_now;
            presence <= pres_now;
            window_closed <= win_now;
            rdata <= req.rd ? rd_next : 32'h0;
            rvalid <= req.rd;
        end
    end
endmodule
`default_nettype wire

/* File: design/rcc_pkg.sv */
// package for the room controller configuration bank
// assumes a register port with word index addressing, 32-bit data
package rcc_pkg;
    localparam logic [7:0] RCC_IDX_TEMP_OFFSET = 8'h08;
    localparam logic [7:0] RCC_IDX_APP_SELECT = 8'h09;
    localparam logic [7:0] RCC_IDX_AUX_FUNC = 8'h0a;
    localparam logic [7:0] RCC_IDX_CYCLE_TIME = 8'h0b;
    localparam logic [7:0] RCC_IDX_SENSOR_SEL = 8'h0d;
    localparam logic [7:0] RCC_IDX_BUS_TEMP = 8'h1e;
    localparam logic [7:0] RCC_IDX_POWERUP_MODE = 8'h19;
    localparam logic [7:0] RCC_IDX_DYN_CORR = 8'h1d;
    localparam logic [7:0] RCC_IDX_CHANGEOVER = 8'h26;
    localparam logic [7:0] RCC_IDX_DEWPOINT = 8'h27;
    localparam logic [7:0] RCC_IDX_PRESENCE = 8'h23;
    localparam logic [7:0] RCC_IDX_EFF_TEMP = 8'h32;
    localparam logic [7:0] RCC_IDX_WINDOW_STAT = 8'h35;
    localparam logic [7:0] RCC_IDX_AUX_STAT = 8'h46;
    localparam logic [7:0] RCC_IDX_OUT_TYPE = 8'h67;
    localparam logic [7:0] RCC_IDX_WIN_POLARITY = 8'h69;
    localparam logic [7:0] RCC_IDX_BUS_OUTPUTS = 8'h80;
    localparam logic [7:0] RCC_IDX_HEAT_DEMAND = 8'h81;
    localparam logic [7:0] RCC_IDX_COOL_DEMAND = 8'h82;
    localparam logic [7:0] RCC_IDX_OPMODE = 8'h83;

    localparam logic [3:0] RCC_RST_APP = 4'h5;
    localparam logic [2:0] RCC_RST_AUX = 3'h0;
    localparam logic [9:0] RCC_RST_CYCLE = 10'h01e;
    localparam logic [9:0] RCC_CYCLE_MIN = 10'h014;
    localparam logic [9:0] RCC_CYCLE_MAX = 10'h258;
    localparam logic [1:0] RCC_RST_SENSOR = 2'h1;
    localparam logic [2:0] RCC_RST_PWRUP = 3'h1;
    localparam logic [2:0] RCC_RST_DYN = 3'h2;
    localparam logic [2:0] RCC_DYN_MAX = 3'h5;
    localparam logic [2:0] RCC_RST_OUT_TYPE = 3'h0;
    localparam logic signed [15:0] RCC_OFFSET_MIN = -16'sh64;
    localparam logic signed [15:0] RCC_OFFSET_MAX = 16'sh64;
    localparam logic [6:0] RCC_DEMAND_MAX = 7'h64;
    localparam logic [1:0] RCC_SENSOR_ONBOARD = 2'h1;
    localparam logic [1:0] RCC_SENSOR_BUS = 2'h2;

    // one second at 100 MHz
    localparam int RCC_TICK_SECONDS = 1;
    localparam int RCC_CLK_HZ = 100_000_000;
    localparam int RCC_TICK_CYCLES = RCC_TICK_SECONDS * RCC_CLK_HZ;

    typedef enum logic [3:0] {
        RCC_APP_BUS = 4'b0000,
        RCC_APP_HEAT = 4'b0001,
        RCC_APP_CHANGEOVER = 4'b0010,
        RCC_APP_COOL = 4'b0011,
        RCC_APP_FOUR_PIPE = 4'b0101,
        RCC_APP_HEAT_DUAL = 4'b0111,
        RCC_APP_CHANGEOVER_DUAL = 4'b1000,
        RCC_APP_COOL_DUAL = 4'b1001
    } rcc_app_type;

    typedef enum logic [2:0] {
        RCC_OUT_PWM = 3'b000,
        RCC_OUT_ANALOG = 3'b001,
        RCC_OUT_HPWM_CANA = 3'b010,
        RCC_OUT_HANA_CPWM = 3'b011,
        RCC_OUT_THREE_POINT = 3'b100
    } rcc_out_type;

    typedef enum logic [2:0] {
        RCC_AUX_NONE = 3'b000,
        RCC_AUX_WINDOW = 3'b001,
        RCC_AUX_CHANGEOVER = 3'b010,
        RCC_AUX_DEWPOINT = 3'b011,
        RCC_AUX_PRESENCE = 3'b100
    } rcc_aux_type;

    typedef enum logic [2:0] {
        RCC_MODE_COMFORT = 3'b000,
        RCC_MODE_REDUCED = 3'b001,
        RCC_MODE_STANDBY = 3'b010,
        RCC_MODE_NIGHT = 3'b101
    } rcc_mode_type;

    // register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [31:0] wdata;
    } rcc_req_type;

    // valve outputs: switched and analogue (0..100 percent)
    typedef struct packed {
        logic sw_a;
        logic sw_b;
        logic [6:0] ana_a;
        logic [6:0] ana_b;
    } rcc_valve_type;
endpackage

/* File: test/rcc_bus_master.sv */
// field-bus master model driving the register request port
// assumes one request at a time; idle contents are inverted, not held
`timescale 1ns/1ps
`default_nettype none
module rcc_bus_master (
    // clock
    input wire logic clk_sys,
    // register request
    output var rcc_pkg::rcc_req_type req
);
    import rcc_pkg::*;
    initial req = '0;
    // one-cycle write or read pulse, then released
    task automatic access(input logic w, input logic [7:0] i,
        input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{wr: w, rd: !w, idx: i, wdata: d};
        @(posedge clk_sys);
        req <= '{wr: 1'b0, rd: 1'b0, idx: ~i, wdata: ~d};
    endtask
endmodule
`default_nettype wire

/* File: test/rcc_config_bank_sva.sv */
// assertions for the room controller configuration bank
// assumes binding to rcc_config_bank; tracks aux function from writes
`timescale 1ns/1ps
`default_nettype none
module rcc_config_bank_sva #(
    parameter int TICK_CYCLES = 10
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire rcc_pkg::rcc_req_type req,
    input wire logic [31:0] rdata,
    // contact and outputs
    input wire logic aux_contact_in,
    input wire logic aux_out,
    input wire logic [2:0] op_mode,
    input wire logic [2:0] dyn_corr,
    input wire logic cooling_mode,
    input wire logic dew_point,
    input wire logic presence
);
    import rcc_pkg::*;
    logic [2:0] func_reg;
    logic [2:0] quiet_reg;
    logic prev_reg;
    logic aux_wr;
    logic dyn_wr;
    logic calm;
    assign aux_wr = req.wr && req.idx == RCC_IDX_AUX_FUNC;
    assign dyn_wr = req.wr && req.idx == RCC_IDX_DYN_CORR;
    assign calm = quiet_reg == 3'h7 && aux_contact_in == prev_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            func_reg <= 3'h0;
            quiet_reg <= 3'h0;
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= aux_contact_in;
            if (aux_wr && req.wdata < 32'h5)
                func_reg <= req.wdata[2:0];
            if (aux_wr || aux_contact_in != prev_reg)
                quiet_reg <= 3'h0;
            else if (quiet_reg != 3'h7)
                quiet_reg <= quiet_reg + 3'h1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_rst_mode;
        $rose(rstn) |-> op_mode == 3'h1 && dyn_corr == 3'h2;
    endproperty
    a_rst_mode: assert property (p_rst_mode)
        else $error("mode not at reset value");
    property p_dyn_take;
        dyn_wr && req.wdata < 32'h6 |-> ##2 dyn_corr == $past(req.wdata, 2);
    endproperty
    a_dyn_take: assert property (p_dyn_take)
        else $error("correction stage not taken");
    property p_dyn_keep;
        dyn_wr && req.wdata > 32'h5 && !$past(req.wr) |->
            ##2 dyn_corr == $past(dyn_corr, 2);
    endproperty
    a_dyn_keep: assert property (p_dyn_keep)
        else $error("bad correction stage taken");
    property p_aux_out;
        req.wr && req.idx == RCC_IDX_BUS_OUTPUTS |->
            ##2 aux_out == $past(req.wdata[2], 2);
    endproperty
    a_aux_out: assert property (p_aux_out)
        else $error("aux output not bus driven");
    property p_aux_stat;
        req.rd && req.idx == RCC_IDX_AUX_STAT && calm |=>
            rdata == {31'h0, $past(aux_contact_in)};
    endproperty
    a_aux_stat: assert property (p_aux_stat)
        else $error("aux status read wrong");
    property p_chg;
        func_reg == 3'h2 && calm |-> cooling_mode == aux_contact_in;
    endproperty
    a_chg: assert property (p_chg)
        else $error("change-over not from contact");
    property p_dew;
        func_reg == 3'h3 && calm |-> dew_point == aux_contact_in;
    endproperty
    a_dew: assert property (p_dew)
        else $error("dew flag not from contact");
    property p_pres;
        func_reg == 3'h4 && calm |-> presence == !aux_contact_in;
    endproperty
    a_pres: assert property (p_pres)
        else $error("presence not from contact");
    c_chg: cover property (func_reg == 3'h2 && cooling_mode);
    c_dew: cover property (func_reg == 3'h3 && dew_point);
    c_pres: cover property (func_reg == 3'h4 && presence);
endmodule
bind rcc_config_bank rcc_config_bank_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .clk_sys(clk_sys), .rstn(rstn), .req(req), .rdata(rdata),
    .aux_contact_in(aux_contact_in), .aux_out(aux_out), .op_mode(op_mode),
    .dyn_corr(dyn_corr), .cooling_mode(cooling_mode),
    .dew_point(dew_point), .presence(presence));
`default_nettype wire

/* File: test/room_ctrl_config_output_routing_test.sv */
// self-checking bench for the room controller configuration bank
// assumes the bus master model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module room_ctrl_config_output_routing_test;
    import rcc_pkg::*;
    localparam int TK = 10;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    rcc_req_type req;
    logic [31:0] rdata;
    logic rvalid;
    logic window_contact_in = 1'b0;
    logic aux_contact_in = 1'b0;
    logic signed [15:0] sensor_temp = 16'sh00c8;
    logic [6:0] heat_demand_in = 7'h00;
    logic [6:0] cool_demand_in = 7'h00;
    rcc_valve_type valve_out;
    logic aux_out, cooling_mode, dew_point, presence, window_closed, b;
    logic signed [15:0] room_temp;
    logic [2:0] op_mode, dyn_corr;
    wire [2:0] bus_pins = {valve_out.sw_a, valve_out.sw_b, aux_out};
    int errors = 0, comparisons = 0, cycles = 0, n = 0;
    int seed = 32'ha8e2;
    logic [31:0] exp_q[$];
    logic [7:0] idx_t[8] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h19,
        8'h1d, 8'h67};
    logic [31:0] rst_t[8] = '{32'h0, 32'h5, 32'h0, 32'h1e, 32'h1, 32'h1,
        32'h2, 32'h0};
    logic [31:0] bad_t[8] = '{32'h65, 32'h4, 32'h5, 32'h259, 32'h0, 32'h3,
        32'h6, 32'h5};
    logic [3:0] app_t[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9};
    // output sources per app: upper nibble first pair, 0 heat 1 cool 2 bus
    logic [7:0] sel_t[8] = '{8'h22, 8'h02, 8'h02, 8'h12, 8'h01, 8'h00,
        8'h00, 8'h11};
    rcc_bus_master u_master (.clk_sys(clk_sys), .req(req));
    rcc_config_bank #(.TICK_CYCLES(TK)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .req(req), .rdata(rdata),
        .rvalid(rvalid), .window_contact_in(window_contact_in),
        .aux_contact_in(aux_contact_in), .sensor_temp(sensor_temp),
        .heat_demand_in(heat_demand_in), .cool_demand_in(cool_demand_in),
        .valve_out(valve_out), .aux_out(aux_out), .room_temp(room_temp),
        .op_mode(op_mode), .dyn_corr(dyn_corr),
        .cooling_mode(cooling_mode), .dew_point(dew_point),
        .presence(presence), .window_closed(window_closed));
    always #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] pick(input logic [3:0] s,
        input logic [6:0] bus);
        return 32'(s == 4'h0 ? heat_demand_in :
            s == 4'h1 ? cool_demand_in : bus);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] i, input logic [31:0] d);
        u_master.access(1'b1, i, d);
    endtask
    task automatic rd_reg(input logic [7:0] i, input logic [31:0] e);
        exp_q.push_back(e);
        u_master.access(1'b0, i, 32'h0);
    endtask
    task automatic settle;
        repeat (10) @(posedge clk_sys);
        #1;
    endtask
    // read results against the oldest note
    always @(posedge clk_sys) begin
        if (rvalid === 1'b1)
            check(rdata, exp_q.size() ? exp_q.pop_front() : 32'hx);
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        heat_demand_in <= 7'($unsigned($random(seed)) % 101);
        cool_demand_in <= 7'($unsigned($random(seed)) % 101);
        sensor_temp <= 16'($unsigned($random(seed)) % 401);
        settle();
        check(32'(op_mode), 32'h1);
        for (int i = 0; i < 8; i++)
            rd_reg(idx_t[i], rst_t[i]);
        for (int i = 0; i < 8; i++)
            wr_reg(idx_t[i], bad_t[i]);
        for (int i = 0; i < 8; i++)
            rd_reg(idx_t[i], rst_t[i]);
        wr_reg(RCC_IDX_BUS_OUTPUTS, 32'h7);
        wr_reg(RCC_IDX_HEAT_DEMAND, 32'h11);
        wr_reg(RCC_IDX_COOL_DEMAND, 32'h22);
        wr_reg(RCC_IDX_OUT_TYPE, 32'h1);
        for (int i = 0; i < 8; i++) begin
            wr_reg(RCC_IDX_APP_SELECT, 32'(app_t[i]));
            settle();
            check(32'(valve_out.ana_a), pick(sel_t[i][7:4], 7'h11));
            check(32'(valve_out.ana_b), pick(sel_t[i][3:0], 7'h22));
            if (i == 0)
                check(32'(bus_pins), 32'h7);
        end
        wr_reg(RCC_IDX_APP_SELECT, 32'h8);
        wr_reg(RCC_IDX_CHANGEOVER, 32'h1);
        settle();
        check(32'(valve_out.ana_b), 32'(cool_demand_in));
        wr_reg(RCC_IDX_APP_SELECT, 32'h5);
        wr_reg(RCC_IDX_OUT_TYPE, 32'h2);
        settle();
        check(32'(valve_out.ana_b), 32'(cool_demand_in));
        wr_reg(RCC_IDX_OUT_TYPE, 32'h3);
        settle();
        check(32'(valve_out.ana_a), 32'(heat_demand_in));
        wr_reg(RCC_IDX_OUT_TYPE, 32'h1);
        for (int f = 2; f < 5; f++) begin
            wr_reg(RCC_IDX_AUX_FUNC, 32'(f));
            for (int c = 0; c < 2; c++) begin
                @(posedge clk_sys);
                aux_contact_in <= c[0];
                settle();
                rd_reg(RCC_IDX_AUX_STAT, 32'(c));
                b = f == 2 ? cooling_mode : f == 3 ? dew_point : !presence;
                check(32'(b), 32'(c));
                if (f == 3 && c == 1)
                    check(32'(valve_out.ana_b), 32'h0);
            end
        end
        wr_reg(RCC_IDX_AUX_FUNC, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr_reg(RCC_IDX_WIN_POLARITY, 32'(p >> 1));
            window_contact_in <= p[0];
            settle();
            check(32'(window_closed), 32'(p[0] == p[1]));
        end
        wr_reg(RCC_IDX_AUX_FUNC, 32'h1);
        aux_contact_in <= 1'b0;
        settle();
        check(32'(window_closed), 32'h0);
        wr_reg(RCC_IDX_AUX_FUNC, 32'h0);
        wr_reg(RCC_IDX_TEMP_OFFSET, 32'hfffffffb);
        settle();
        check(32'(room_temp), 32'(sensor_temp - 16'sh5));
        wr_reg(RCC_IDX_BUS_TEMP, 32'he6);
        wr_reg(RCC_IDX_SENSOR_SEL, 32'h2);
        wr_reg(RCC_IDX_DYN_CORR, 32'h5);
        settle();
        check(32'(room_temp), 32'he6);
        check(32'(dyn_corr), 32'h5);
        wr_reg(RCC_IDX_OUT_TYPE, 32'h0);
        wr_reg(RCC_IDX_CYCLE_TIME, 32'h14);
        settle();
        repeat (400) begin
            @(posedge clk_sys);
            n += valve_out.sw_a === 1'b1;
        end
        check(32'(n), 32'(2 * TK * ((heat_demand_in + 4) / 5)));
        wr_reg(RCC_IDX_OUT_TYPE, 32'h4);
        heat_demand_in <= 7'h00;
        repeat (300) @(posedge clk_sys);
        wr_reg(RCC_IDX_CYCLE_TIME, 32'h14);
        heat_demand_in <= 7'h64;
        n = 0;
        repeat (300) begin
            @(posedge clk_sys);
            n += valve_out.sw_a === 1'b1;
        end
        check(32'(n), 32'(20 * TK - 1));
        check(32'(valve_out.sw_b), 32'h0);
        settle();
        check(32'(exp_q.size()), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
